// >>> rtl/dps_cke_ctl.sv
`timescale 1ns/1ps
module dps_cke_ctl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic a10,
    input wire logic odt,
    output logic [2:0] pwr_state,
    output logic in_power_down,
    output logic in_self_refresh,
    output logic refresh_active,
    output logic all_idle,
    output logic odt_enable,
    output logic illegal_cmd,
    output logic [7:0] banks_open
);
    // ========================================
    // state and registers
    dps_pkg::dps_state_t state_q, state_d;
    logic cke_q;
    logic [3:0] busy_q, busy_d;
    logic ref_q, ref_d;
    logic odt_q;
    logic ill_q, ill_d;
    dps_bank_if bif ();

    dps_bank_track u_track (
        .mclk(mclk),
        .rst(rst),
        .bif(bif)
    );

    // ========================================
    // command decode at the edge
    wire cmd_live = (cke_q && cke);
    wire desel_or_nop = cs_n || ({ras_n, cas_n, we_n} == dps_pkg::CMD_NOP);
    wire [2:0] cmd = {ras_n, cas_n, we_n};
    wire valid_cmd = cmd_live && !cs_n && (cmd != dps_pkg::CMD_NOP);
    wire is_act = valid_cmd && (cmd == dps_pkg::CMD_ACT);
    wire is_pre = valid_cmd && (cmd == dps_pkg::CMD_PRE);
    wire is_ref = valid_cmd && (cmd == dps_pkg::CMD_REF);
    wire is_rw = valid_cmd && (cmd == dps_pkg::CMD_RD || cmd == dps_pkg::CMD_WR);
    wire fall = cke_q && !cke;
    wire rise = !cke_q && cke;
    wire is_sre = fall && !cs_n && (cmd == dps_pkg::CMD_REF);
    wire in_low = (state_q == dps_pkg::DPS_APD) || (state_q == dps_pkg::DPS_PPD) ||
                  (state_q == dps_pkg::DPS_SREF);
    wire any_open = (bif.open_q != dps_pkg::NO_BANKS);
    // idle: banks closed, no burst, no refresh, cke high
    wire idle_now = !any_open && (busy_q == 4'h0) && !ref_q && cke_q;

    // bank tracker only sees commands while awake, a10 picks precharge-all
    assign bif.act_v = is_act && !in_low;
    assign bif.pre_v = is_pre && !in_low;
    assign bif.pre_all = a10;
    assign bif.bank = ba;

    // ========================================
    // busy timer for bursts and precharge; refresh flag
    // fixed short counts stand in for the real burst and recovery times
    always_comb begin
        busy_d = (busy_q != 4'h0) ? busy_q - 4'h1 : 4'h0;
        ref_d = ref_q;
        if (is_rw && !in_low) begin
            busy_d = dps_pkg::BURST_CNT;
        end else if (is_pre && !in_low) begin
            busy_d = dps_pkg::PRE_CNT;
        end
        if (is_ref && !in_low) begin
            ref_d = 1'b1;
            busy_d = dps_pkg::REF_CNT;
        end else if (busy_q == 4'h1 || in_low) begin
            ref_d = 1'b0;
        end
    end

    // ========================================
    // transition decision from previous cke, current cke, prior state
    always_comb begin
        state_d = state_q;
        ill_d = 1'b0;
        case (state_q)
            dps_pkg::DPS_IDLE, dps_pkg::DPS_ACTIVE: begin
                if (fall) begin
                    if (is_sre) begin
                        if (idle_now) begin
                            state_d = dps_pkg::DPS_SREF;
                        end else begin
                            ill_d = 1'b1;
                        end
                    end else if (desel_or_nop) begin
                        // bank state after a finishing command is what counts
                        state_d = (any_open || bif.act_v) ? dps_pkg::DPS_APD : dps_pkg::DPS_PPD;
                    end else begin
                        ill_d = 1'b1;
                    end
                end else begin
                    state_d = (bif.open_q != dps_pkg::NO_BANKS) ? dps_pkg::DPS_ACTIVE : dps_pkg::DPS_IDLE;
                end
            end
            dps_pkg::DPS_APD, dps_pkg::DPS_PPD: begin
                if (rise) begin
                    state_d = any_open ? dps_pkg::DPS_ACTIVE : dps_pkg::DPS_IDLE;
                    ill_d = !desel_or_nop;
                end
            end
            dps_pkg::DPS_SREF: begin
                // exit on cke rise alone, command pins not needed
                if (cke) begin
                    state_d = dps_pkg::DPS_IDLE;
                end else begin
                    state_d = dps_pkg::DPS_SREF;
                end
            end
            default: begin
                state_d = dps_pkg::DPS_IDLE;
            end
        endcase
    end

    // ========================================
    // registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= dps_pkg::DPS_IDLE;
            cke_q <= 1'b0;
            busy_q <= 4'h0;
            ref_q <= 1'b0;
            ill_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cke_q <= cke;
            busy_q <= busy_d;
            ref_q <= ref_d;
            ill_q <= ill_d;
        end
    end

    // odt only gates output, never the state walk
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            odt_q <= 1'b0;
        end else begin
            odt_q <= odt && (state_d != dps_pkg::DPS_SREF);
        end
    end

    // ========================================
    // outputs
    assign pwr_state = state_q;
    assign in_power_down = (state_q == dps_pkg::DPS_APD) || (state_q == dps_pkg::DPS_PPD);
    assign in_self_refresh = (state_q == dps_pkg::DPS_SREF);
    assign refresh_active = ref_q;
    assign all_idle = (state_q == dps_pkg::DPS_IDLE) && idle_now;
    assign odt_enable = odt_q;
    assign illegal_cmd = ill_q;
    assign banks_open = bif.open_q;

    // ========================================
    // named steps shared by the checks below
    // awake state sees clock enable fall with nop or deselect
    sequence s_pd_enter;
        !in_low && fall && desel_or_nop;
    endsequence

    // awake state sees refresh on a falling clock enable, nothing pending
    sequence s_sr_request;
        !in_low && is_sre && idle_now;
    endsequence

    // same request while a bank, burst or refresh is still open
    sequence s_sr_early;
        !in_low && is_sre && !idle_now;
    endsequence

    // awake state sees a falling clock enable with a real command
    sequence s_bad_fall;
        !in_low && fall && !desel_or_nop && !is_sre;
    endsequence

    // powered down and clock enable comes back
    sequence s_pd_leave;
        in_power_down && rise;
    endsequence

    // one cycle awake, the next in self refresh
    sequence s_sr_arrive;
        (state_q != dps_pkg::DPS_SREF) ##1 (state_q == dps_pkg::DPS_SREF);
    endsequence

    // ========================================
    // checks on entry into the low power states
    a_sr_hold: assert property (@(posedge mclk) disable iff (rst)
        (state_q == dps_pkg::DPS_SREF && !cke) |=> (state_q == dps_pkg::DPS_SREF))
        else $error("self refresh not held");

    // the decision edge must have seen every idle condition
    a_sr_entry: assert property (@(posedge mclk) disable iff (rst)
        s_sr_arrive |-> $past(idle_now))
        else $error("self refresh entered when not idle");

    // a granted request lands in self refresh on the next edge
    a_sr_taken: assert property (@(posedge mclk) disable iff (rst)
        s_sr_request |=> in_self_refresh)
        else $error("self refresh request not taken");

    // an early request is flagged and leaves the state alone
    a_sr_refused: assert property (@(posedge mclk) disable iff (rst)
        s_sr_early |=> (illegal_cmd && !in_self_refresh))
        else $error("early self refresh not refused");

    // open banks pick active power-down, even while the state name lags
    a_apd_entry: assert property (@(posedge mclk) disable iff (rst)
        (s_pd_enter ##0 any_open) |=> (state_q == dps_pkg::DPS_APD))
        else $error("active power-down missed");

    // closed banks, even with a refresh still running, pick precharge power-down
    a_ppd_entry: assert property (@(posedge mclk) disable iff (rst)
        (s_pd_enter ##0 !any_open) |=> (state_q == dps_pkg::DPS_PPD))
        else $error("precharge power-down missed");

    // deselect on the falling edge counts exactly as nop
    a_desel_pd: assert property (@(posedge mclk) disable iff (rst)
        (s_pd_enter ##0 cs_n) |=> (in_power_down && !illegal_cmd))
        else $error("deselect not taken as nop");

    // a real command on the falling edge is flagged, state held
    a_bad_fall: assert property (@(posedge mclk) disable iff (rst)
        s_bad_fall |=> (illegal_cmd && state_q == $past(state_q)))
        else $error("bad command on cke fall not refused");

    // ========================================
    // checks while powered down and on the way out
    a_pd_banks: assert property (@(posedge mclk) disable iff (rst)
        in_power_down ##1 in_power_down |-> $stable(bif.open_q))
        else $error("banks changed in power-down");
    a_no_refresh: assert property (@(posedge mclk) disable iff (rst)
        in_low |=> !ref_q)
        else $error("refresh during power-down");
    a_sr_exit: assert property (@(posedge mclk) disable iff (rst)
        (state_q == dps_pkg::DPS_SREF && cke) |=> (state_q == dps_pkg::DPS_IDLE))
        else $error("self refresh exit missed");
    a_odt_sr: assert property (@(posedge mclk) disable iff (rst)
        (state_q == dps_pkg::DPS_SREF) |-> !odt_enable)
        else $error("termination in self refresh");
    a_idle_def: assert property (@(posedge mclk) disable iff (rst)
        all_idle |-> (banks_open == 8'h00 && !refresh_active))
        else $error("idle with work pending");

    // a burst started in the last four cycles rules out idle
    a_idle_burst: assert property (@(posedge mclk) disable iff (rst)
        all_idle |-> (!$past(is_rw) && !$past(is_rw, 2) && !$past(is_rw, 3) && !$past(is_rw, 4)))
        else $error("idle during a burst");

    // a refresh taken while awake shows as active on the next edge
    a_ref_start: assert property (@(posedge mclk) disable iff (rst)
        (is_ref && !in_low) |=> refresh_active)
        else $error("refresh not tracked");

    // banks cannot change under self refresh either
    a_sr_banks: assert property (@(posedge mclk) disable iff (rst)
        in_self_refresh ##1 in_self_refresh |-> $stable(banks_open))
        else $error("banks changed in self refresh");

    // clock enable back up leaves power-down on the next edge
    a_pd_exit: assert property (@(posedge mclk) disable iff (rst)
        s_pd_leave |=> !in_low)
        else $error("power-down exit missed");

    // only the five defined codes ever appear
    a_state_legal: assert property (@(posedge mclk) disable iff (rst)
        state_q inside {dps_pkg::DPS_IDLE, dps_pkg::DPS_ACTIVE, dps_pkg::DPS_APD, dps_pkg::DPS_PPD, dps_pkg::DPS_SREF})
        else $error("undefined power state");
endmodule

// >>> rtl/dps_pkg.sv
package dps_pkg;
    // ========================================
    // command encoding, {ras_n, cas_n, we_n} with cs_n low
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_ZQ = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ========================================
    // sizes and fixed counts
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam logic [3:0] BURST_CNT = 4'h4;
    localparam logic [3:0] PRE_CNT = 4'h3;
    localparam logic [3:0] REF_CNT = 4'h8;
    localparam logic [7:0] NO_BANKS = 8'h00;

    // ========================================
    // power state, gray coded along idle -> pd -> sr path
    typedef enum logic [2:0] {
        DPS_IDLE = 3'h0,
        DPS_ACTIVE = 3'h1,
        DPS_APD = 3'h3,
        DPS_PPD = 3'h2,
        DPS_SREF = 3'h6
    } dps_state_t;
endpackage

// >>> rtl/dps_bank_if.sv
`timescale 1ns/1ps
// bank bookkeeping link between control and tracker
interface dps_bank_if;
    logic act_v;
    logic pre_v;
    logic pre_all;
    logic [2:0] bank;
    logic [7:0] open_q;
    modport ctl (output act_v, output pre_v, output pre_all, output bank, input open_q);
    modport trk (input act_v, input pre_v, input pre_all, input bank, output open_q);
endinterface

// >>> rtl/dps_bank_track.sv
`timescale 1ns/1ps
// ========================================
// per-bank open flags
module dps_bank_track (
    input wire logic mclk,
    input wire logic rst,
    dps_bank_if.trk bif
);
    logic [dps_pkg::NUM_BANKS-1:0] open_d;

    // one flag per bank, activate sets, precharge clears
    for (genvar b = 0; b < dps_pkg::NUM_BANKS; b++) begin : g_bank
        wire hit = (bif.bank == 3'(b));
        assign open_d[b] = (bif.act_v && hit) ? 1'b1 :
                           ((bif.pre_v && (hit || bif.pre_all)) ? 1'b0 : bif.open_q[b]);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bif.open_q <= dps_pkg::NO_BANKS;
        end else begin
            bif.open_q <= open_d;
        end
    end
endmodule

// >>> tb/dps_mc_model.sv
`timescale 1ns/1ps
// ========================================
// controller stand-in driving cke and command pins
module dps_mc_model (
    input wire logic mclk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic a10,
    output logic odt
);
    // pins start deselected with cke low, as before power-up
    initial begin
        cke = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        ba = 3'h0;
        a10 = 1'b0;
        odt = 1'b0;
    end

    // one command per cycle, launched on the falling edge
    task automatic issue(input logic c, input logic sel, input logic [2:0] op, input logic [2:0] b, input logic ap);
        @(negedge mclk);
        cke = c;
        cs_n = ~sel;
        // deselected pins toggle, a stale level never passes as valid
        {ras_n, cas_n, we_n} = sel ? op : ~{ras_n, cas_n, we_n};
        ba = sel ? b : ~ba;
        a10 = sel ? ap : ~a10;
    endtask

    // nop or deselect on every cke edge, level held n cycles
    task automatic nops(input int n, input logic c, input logic sel);
        for (int i = 0; i < n; i++) begin
            issue(c, sel, dps_pkg::CMD_NOP, 3'h0, 1'b0);
        end
    endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, a10, odt;
    logic [2:0] ba;
    logic [2:0] pwr_state;
    logic in_power_down, in_self_refresh, refresh_active, all_idle, odt_enable, illegal_cmd;
    logic [7:0] banks_open;
    int num_errors = 0;
    int cmp_count = 0;

    always #2 mclk = ~mclk;

    dps_mc_model MC (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .a10(a10), .odt(odt));
    dps_cke_ctl DUT (.mclk(mclk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .a10(a10), .odt(odt), .pwr_state(pwr_state), .in_power_down(in_power_down),
        .in_self_refresh(in_self_refresh), .refresh_active(refresh_active), .all_idle(all_idle),
        .odt_enable(odt_enable), .illegal_cmd(illegal_cmd), .banks_open(banks_open));

    // ========================================
    // comparison helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bounded wait, the answer may land up to four edges later
    task automatic see(input logic [2:0] exp);
        for (int i = 0; i < 4 && pwr_state !== exp; i++) begin
            @(negedge mclk);
        end
        chk("pwr_state", {5'h0, exp}, {5'h0, pwr_state});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic t_active_pd();
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_ACT, 3'h2, 1'b0);
        MC.nops(1, 1'b1, 1'b1);
        see(dps_pkg::DPS_ACTIVE);
        chk("banks_open", 8'h04, banks_open);
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_RD, 3'h2, 1'b0);
        MC.nops(1, 1'b0, 1'b1);
        see(dps_pkg::DPS_APD);
        chk("in_power_down", 8'h01, {7'h0, in_power_down});
        MC.issue(1'b0, 1'b1, dps_pkg::CMD_PRE, 3'h0, 1'b1);
        MC.nops(2, 1'b0, 1'b0);
        chk("banks_open", 8'h04, banks_open);
        see(dps_pkg::DPS_APD);
        MC.nops(1, 1'b1, 1'b0);
        see(dps_pkg::DPS_ACTIVE);
        $display("done active power-down");
    endtask

    task automatic t_pre_pd();
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_PRE, 3'h0, 1'b1);
        MC.nops(1, 1'b0, 1'b1);
        see(dps_pkg::DPS_PPD);
        chk("banks_open", 8'h00, banks_open);
        MC.nops(2, 1'b0, 1'b1);
        MC.nops(5, 1'b1, 1'b1);
        see(dps_pkg::DPS_IDLE);
        chk("all_idle", 8'h01, {7'h0, all_idle});
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_REF, 3'h0, 1'b0);
        MC.nops(1, 1'b1, 1'b1);
        chk("refresh_active", 8'h01, {7'h0, refresh_active});
        chk("all_idle", 8'h00, {7'h0, all_idle});
        MC.nops(1, 1'b0, 1'b0);
        see(dps_pkg::DPS_PPD);
        MC.nops(2, 1'b0, 1'b0);
        chk("refresh_active", 8'h00, {7'h0, refresh_active});
        MC.nops(12, 1'b1, 1'b1);
        see(dps_pkg::DPS_IDLE);
        $display("done precharge power-down");
    endtask

    task automatic t_self_refresh();
        MC.odt = 1'b1;
        MC.nops(2, 1'b1, 1'b1);
        chk("odt_enable", 8'h01, {7'h0, odt_enable});
        MC.issue(1'b0, 1'b1, dps_pkg::CMD_REF, 3'h0, 1'b0);
        see(dps_pkg::DPS_SREF);
        MC.issue(1'b0, 1'b1, dps_pkg::CMD_ACT, 3'h3, 1'b0);
        MC.nops(5, 1'b0, 1'b0);
        see(dps_pkg::DPS_SREF);
        chk("in_self_refresh", 8'h01, {7'h0, in_self_refresh});
        chk("odt_enable", 8'h00, {7'h0, odt_enable});
        chk("banks_open", 8'h00, banks_open);
        MC.odt = 1'b0;
        MC.nops(1, 1'b1, 1'b1);
        see(dps_pkg::DPS_IDLE);
        MC.nops(12, 1'b1, 1'b1);
        $display("done self refresh");
    endtask

    task automatic t_bad_entry();
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_ACT, 3'h5, 1'b0);
        MC.nops(2, 1'b1, 1'b1);
        MC.issue(1'b0, 1'b1, dps_pkg::CMD_REF, 3'h0, 1'b0);
        for (int i = 0; i < 3 && illegal_cmd !== 1'b1; i++) begin
            @(negedge mclk);
        end
        chk("illegal_cmd", 8'h01, {7'h0, illegal_cmd});
        see(dps_pkg::DPS_ACTIVE);
        $display("done refused entry");
    endtask

    // write, single-bank close, then a real command on the falling edge
    task automatic t_bad_cmd();
        MC.nops(2, 1'b1, 1'b1);
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_WR, 3'h5, 1'b0);
        MC.issue(1'b1, 1'b1, dps_pkg::CMD_PRE, 3'h5, 1'b0);
        MC.nops(1, 1'b1, 1'b1);
        chk("banks_open", 8'h00, banks_open);
        MC.issue(1'b0, 1'b1, dps_pkg::CMD_ACT, 3'h1, 1'b0);
        for (int i = 0; i < 3 && illegal_cmd !== 1'b1; i++) begin
            @(negedge mclk);
        end
        chk("illegal_cmd", 8'h01, {7'h0, illegal_cmd});
        see(dps_pkg::DPS_IDLE);
        chk("banks_open", 8'h00, banks_open);
        MC.nops(1, 1'b0, 1'b1);
        chk("illegal_cmd", 8'h00, {7'h0, illegal_cmd});
        $display("done refused command");
    endtask

    // watchdog well beyond the hundred or so cycles the scenarios need
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        MC.nops(2, 1'b1, 1'b1);
        t_active_pd();
        t_pre_pd();
        t_self_refresh();
        t_bad_entry();
        t_bad_cmd();
        tally_and_finish();
    end
endmodule
